// *** src/pfs_packet_fifo_flags.sv ***
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_packet_fifo_flags import pfs_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // axi4-lite write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // demodulator link, asynchronous
    input wire logic linkClk,
    input wire logic rxBit,
    // modulator output
    output logic txBit,
    // status sources from the rest of the chip
    input wire logic lowBattery,
    input wire logic autoSequence,
    input wire logic modeSwitchDone,
    input wire logic dividedClock,
    input wire logic synthLocked,
    // general pins
    output logic [5:0] generalPin
);
    function automatic logic [3:0] popCount(input logic [63:0] v);
        logic [6:0] n;
        n = 7'd0;
        for (int i = 0; i < 64; i++) begin
            n = n + {6'd0, v[i]};
        end
        return (n > 7'd7) ? 4'd8 : n[3:0];
    endfunction

    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic pick(input logic [1:0] s, input logic a, input logic b,
                                  input logic c, input logic d);
        return (s == 2'b00) ? a : (s == 2'b01) ? b : (s == 2'b10) ? c : d;
    endfunction

    // register state
    pfs_mode_e mode_reg;
    logic contMode_reg, bitSync_reg;
    logic [6:0] thr_reg;
    logic [7:0] pcfg_reg, map1_reg, map2_reg;
    logic [63:0] pval_reg;
    logic overrun_reg, level_reg, levelValid_reg, sent_reg, match_reg, hasData_reg;

    // buffer state
    pfs_byte_t mem_reg [0:65];
    logic [6:0] wrPtr_reg, rdPtr_reg, count_reg;

    // bus state
    logic [7:0] awAddr_reg;
    logic awHave_reg, wHave_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;

    // link state
    logic [2:0] clkSync_reg;
    logic [1:0] rxSync_reg;
    logic [7:0] rxSr_reg, txSr_reg;
    logic [3:0] rxCnt_reg, txCnt_reg;
    logic txBusy_reg;
    logic [63:0] patSr_reg;
    logic [6:0] patCnt_reg;

    // bus decode
    wire doWrite = awHave_reg && wHave_reg && !bvalid;
    wire [7:0] wa = awAddr_reg;
    wire [31:0] wd = mergeStrb(32'h0, wData_reg, wStrb_reg);
    wire wrMode = doWrite && wa == `PFS_OFF_MODE && wStrb_reg[0];
    wire wrFifo = doWrite && wa == `PFS_OFF_FIFO && wStrb_reg[0];
    wire wrStat = doWrite && wa == `PFS_OFF_STAT && wStrb_reg[0];
    wire wrThr = doWrite && wa == `PFS_OFF_THR && wStrb_reg[0];
    wire wrPcfg = doWrite && wa == `PFS_OFF_PCFG && wStrb_reg[0];
    wire wrPhi = doWrite && wa == `PFS_OFF_PHI;
    wire wrPlo = doWrite && wa == `PFS_OFF_PLO;
    wire wrMap1 = doWrite && wa == `PFS_OFF_MAP1 && wStrb_reg[0];
    wire wrMap2 = doWrite && wa == `PFS_OFF_MAP2 && wStrb_reg[0];
    wire wrHit = wa == `PFS_OFF_MODE || wa == `PFS_OFF_FIFO || wa == `PFS_OFF_STAT ||
                 wa == `PFS_OFF_THR || wa == `PFS_OFF_PCFG || wa == `PFS_OFF_PHI ||
                 wa == `PFS_OFF_PLO || wa == `PFS_OFF_MAP1 || wa == `PFS_OFF_MAP2;
    wire doRead = arvalid && !rvalid;
    wire rdHit = araddr == `PFS_OFF_MODE || araddr == `PFS_OFF_FIFO ||
                 araddr == `PFS_OFF_STAT || araddr == `PFS_OFF_THR ||
                 araddr == `PFS_OFF_PCFG || araddr == `PFS_OFF_PHI ||
                 araddr == `PFS_OFF_PLO || araddr == `PFS_OFF_MAP1 ||
                 araddr == `PFS_OFF_MAP2;

    // mode transitions
    wire [2:0] newModeRaw = wd[`PFS_MODE_HI:`PFS_MODE_LO];
    wire modeLegal = newModeRaw <= 3'(PFS_TX);
    pfs_mode_e newMode;
    assign newMode = pfs_mode_e'(newModeRaw);
    wire modeChange = wrMode && modeLegal && newMode != mode_reg;
    wire modeClear = modeChange && (
        ((mode_reg == PFS_SLEEP || mode_reg == PFS_STDBY) && newMode == PFS_RX) ||
        (mode_reg == PFS_RX && newMode == PFS_TX) ||
        (mode_reg == PFS_TX));
    wire ovrClear = wrStat && wd[`PFS_ST_OVR];
    wire bufClear = modeClear || ovrClear;
    wire inRx = mode_reg == PFS_RX;
    wire inTx = mode_reg == PFS_TX;
    wire packetMode = !contMode_reg;

    // link edge detect on the synchronised clock
    wire linkRise = clkSync_reg[1] && !clkSync_reg[2];
    wire inBit = rxSync_reg[1];

    // buffer access
    wire full = count_reg == `PFS_DEPTH;
    wire empty = count_reg == 7'd0;
    wire rxByteDone = packetMode && inRx && linkRise && rxCnt_reg == 4'd7;
    wire hostPush = wrFifo && !inRx;
    wire pushReq = hostPush || rxByteDone;
    wire push = pushReq && !full;
    wire overrunEvt = pushReq && full;
    wire txLoad = packetMode && inTx && linkRise && !txBusy_reg && !empty;
    wire hostPop = doRead && araddr == `PFS_OFF_FIFO && !inTx && !empty;
    wire pop = txLoad || hostPop;
    wire [7:0] pushByte = hostPush ? wd[7:0] : {rxSr_reg[6:0], inBit};
    wire [6:0] countNext = count_reg + {6'd0, push} - {6'd0, pop};
    wire [6:0] wrPtrInc = (wrPtr_reg == `PFS_LAST_IDX) ? 7'd0 : wrPtr_reg + 7'd1;
    wire [6:0] rdPtrInc = (rdPtr_reg == `PFS_LAST_IDX) ? 7'd0 : rdPtr_reg + 7'd1;
    wire access = push || pop || pushReq || (doRead && araddr == `PFS_OFF_FIFO);
    wire becameEmpty = (!empty && countNext == 7'd0) || bufClear;

    // pattern detector
    wire [3:0] patBytes = {1'b0, pcfg_reg[`PFS_PC_LEN_HI:`PFS_PC_LEN_LO]} + 4'd1;
    wire [6:0] patBits = {patBytes, 3'b000};
    wire [63:0] patMask = 64'hffffffffffffffff >> (7'd64 - patBits);
    wire [63:0] patTarget = pval_reg >> (7'd64 - patBits);
    wire [63:0] patNext = {patSr_reg[62:0], inBit};
    wire [3:0] patErr = popCount((patNext ^ patTarget) & patMask);
    wire patOn = pcfg_reg[`PFS_PC_EN] && inRx && (packetMode || bitSync_reg);
    wire patHit = patOn && linkRise && patCnt_reg >= patBits - 7'd1 &&
                  patErr <= {1'b0, pcfg_reg[`PFS_PC_TOL_HI:`PFS_PC_TOL_LO]};

    // transmit frame end
    wire txLastOut = inTx && linkRise && txBusy_reg && txCnt_reg == 4'd1;
    wire frameDone = txLastOut && (empty || !packetMode);

    // bus handshakes
    assign awready = !awHave_reg;
    assign wready = !wHave_reg;
    assign arready = !rvalid;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0;
            wStrb_reg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `PFS_RESP_OK;
        end else begin
            if (awvalid && awready) begin
                awHave_reg <= 1'b1;
                awAddr_reg <= awaddr;
            end else if (doWrite) begin
                awHave_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                wHave_reg <= 1'b1;
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
            end else if (doWrite) begin
                wHave_reg <= 1'b0;
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= wrHit ? `PFS_RESP_OK : `PFS_RESP_ERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read data
    wire [31:0] statWord = {26'd0, match_reg, sent_reg, level_reg, overrun_reg, full, hasData_reg};
    wire [31:0] rdWord =
        araddr == `PFS_OFF_MODE ? {27'd0, bitSync_reg, contMode_reg, 3'(mode_reg)} :
        araddr == `PFS_OFF_FIFO ? {24'd0, (hostPop ? mem_reg[rdPtr_reg] : 8'h00)} :
        araddr == `PFS_OFF_STAT ? statWord :
        araddr == `PFS_OFF_THR ? {25'd0, thr_reg} :
        araddr == `PFS_OFF_PCFG ? {24'd0, pcfg_reg} :
        araddr == `PFS_OFF_PHI ? pval_reg[63:32] :
        araddr == `PFS_OFF_PLO ? pval_reg[31:0] :
        araddr == `PFS_OFF_MAP1 ? {24'd0, map1_reg} :
        araddr == `PFS_OFF_MAP2 ? {24'd0, map2_reg} : 32'h0;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `PFS_RESP_OK;
        end else if (doRead) begin
            rvalid <= 1'b1;
            rdata <= rdWord;
            rresp <= rdHit ? `PFS_RESP_OK : `PFS_RESP_ERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            mode_reg <= PFS_STDBY;
            contMode_reg <= 1'b0;
            bitSync_reg <= 1'b0;
            thr_reg <= `PFS_THR_RST;
            pcfg_reg <= `PFS_PCFG_RST;
            pval_reg <= `PFS_PVAL_RST;
            map1_reg <= 8'h00;
            map2_reg <= 8'h00;
        end else begin
            if (wrMode && modeLegal) begin
                mode_reg <= newMode;
            end
            if (wrMode) begin
                contMode_reg <= wd[`PFS_MODE_CONT];
                bitSync_reg <= wd[`PFS_MODE_BSYNC];
            end
            if (wrThr) begin
                thr_reg <= wd[6:0];
            end
            if (wrPcfg) begin
                pcfg_reg <= wd[7:0];
            end
            if (wrPhi) begin
                pval_reg[63:32] <= mergeStrb(pval_reg[63:32], wData_reg, wStrb_reg);
            end
            if (wrPlo) begin
                pval_reg[31:0] <= mergeStrb(pval_reg[31:0], wData_reg, wStrb_reg);
            end
            if (wrMap1) begin
                map1_reg <= wd[7:0];
            end
            if (wrMap2) begin
                map2_reg <= wd[7:0];
            end
        end
    end

    // buffer storage and pointers
    always_ff @(posedge mclk) begin
        if (push && !bufClear) begin
            mem_reg[wrPtr_reg] <= pushByte;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn || bufClear) begin
            wrPtr_reg <= 7'd0;
            rdPtr_reg <= 7'd0;
            count_reg <= 7'd0;
        end else begin
            wrPtr_reg <= push ? wrPtrInc : wrPtr_reg;
            rdPtr_reg <= pop ? rdPtrInc : rdPtr_reg;
            count_reg <= countNext;
        end
    end

    // buffer flags
    wire levelNext = (countNext > thr_reg) && levelValid_reg && countNext != `PFS_DEPTH;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hasData_reg <= 1'b0;
            overrun_reg <= 1'b0;
            level_reg <= 1'b0;
            levelValid_reg <= 1'b1;
        end else begin
            hasData_reg <= bufClear ? 1'b0 : countNext != 7'd0;
            overrun_reg <= overrunEvt || (overrun_reg && !ovrClear);
            if (bufClear || countNext == 7'd0) begin
                levelValid_reg <= 1'b1;
            end else if (countNext == `PFS_DEPTH) begin
                levelValid_reg <= 1'b0;
            end
            if (bufClear) begin
                level_reg <= 1'b0;
            end else if (access) begin
                level_reg <= levelNext;
            end
        end
    end

    // link sampling, receive and transmit shifters
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clkSync_reg <= 3'b000;
            rxSync_reg <= 2'b00;
            rxSr_reg <= 8'h00;
            rxCnt_reg <= 4'd0;
            txSr_reg <= 8'h00;
            txCnt_reg <= 4'd0;
            txBusy_reg <= 1'b0;
            txBit <= 1'b0;
            sent_reg <= 1'b0;
        end else begin
            clkSync_reg <= {clkSync_reg[1:0], linkClk};
            rxSync_reg <= {rxSync_reg[0], rxBit};
            if (!inRx) begin
                rxCnt_reg <= 4'd0;
            end else if (linkRise) begin
                rxSr_reg <= {rxSr_reg[6:0], inBit};
                rxCnt_reg <= (rxCnt_reg == 4'd7) ? 4'd0 : rxCnt_reg + 4'd1;
            end
            if (!inTx || !packetMode) begin
                txBusy_reg <= 1'b0;
                txCnt_reg <= 4'd0;
            end else if (txLoad) begin
                txSr_reg <= {mem_reg[rdPtr_reg][6:0], 1'b0};
                txBit <= mem_reg[rdPtr_reg][7];
                txCnt_reg <= 4'd8;
                txBusy_reg <= 1'b1;
            end else if (linkRise && txBusy_reg) begin
                txBit <= txSr_reg[7];
                txSr_reg <= {txSr_reg[6:0], 1'b0};
                txCnt_reg <= txCnt_reg - 4'd1;
                txBusy_reg <= txCnt_reg != 4'd1;
            end
            if (modeChange && newMode == PFS_TX) begin
                sent_reg <= 1'b0;
            end else if (frameDone) begin
                sent_reg <= 1'b1;
            end
        end
    end

    // pattern shifter and match flag
    always_ff @(posedge mclk) begin
        if (!rstn || !patOn) begin
            patSr_reg <= 64'h0;
            patCnt_reg <= 7'd0;
        end else if (linkRise) begin
            patSr_reg <= patNext;
            patCnt_reg <= (patCnt_reg == 7'd64) ? patCnt_reg : patCnt_reg + 7'd1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            match_reg <= 1'b0;
        end else if (patHit) begin
            match_reg <= 1'b1;
        end else if ((modeChange && inRx) || becameEmpty) begin
            match_reg <= 1'b0;
        end
    end

    // continuous-mode pin routing
    wire actv = inRx || inTx;
    wire serData = inRx ? inBit : txBit;
    wire bitClk = clkSync_reg[1];
    wire sel00Clk = mode_reg != PFS_SLEEP && dividedClock;
    wire [5:0] contPins;
    assign contPins[5] = pick(map2_reg[5:4], sel00Clk, inTx && dividedClock,
                              lowBattery, modeSwitchDone);
    assign contPins[4] = pick(map2_reg[7:6], 1'b0, 1'b0, inRx ? match_reg : lowBattery,
                              mode_reg != PFS_SLEEP && mode_reg != PFS_STDBY && synthLocked);
    assign contPins[3] = pick(map1_reg[1:0], 1'b0, 1'b0, autoSequence, 1'b0);
    assign contPins[2] = actv && serData;
    assign contPins[1] = pick(map1_reg[5:4], actv && (inTx || bitSync_reg) && bitClk, 1'b0,
                              lowBattery, inRx ? match_reg : (mode_reg != PFS_SLEEP &&
                              mode_reg != PFS_STDBY && synthLocked));
    assign contPins[0] = pick(map1_reg[7:6], inRx ? match_reg : ((mode_reg == PFS_FS ||
                              inTx) && synthLocked), 1'b0, !inRx && lowBattery,
                              modeSwitchDone);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            generalPin <= 6'h00;
        end else begin
            generalPin <= contMode_reg ? contPins : 6'h00;
        end
    end

endmodule // pfs_packet_fifo_flags

// *** src/pfs_defines.svh ***
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// register byte offsets
`define PFS_OFF_MODE 8'h00
`define PFS_OFF_FIFO 8'h04
`define PFS_OFF_STAT 8'h08
`define PFS_OFF_THR 8'h0c
`define PFS_OFF_PCFG 8'h10
`define PFS_OFF_PHI 8'h14
`define PFS_OFF_PLO 8'h18
`define PFS_OFF_MAP1 8'h1c
`define PFS_OFF_MAP2 8'h20

// mode register fields
`define PFS_MODE_LO 0
`define PFS_MODE_HI 2
`define PFS_MODE_CONT 3
`define PFS_MODE_BSYNC 4
`define PFS_MODE_RST 5'h01

// status register bits
`define PFS_ST_DATA 0
`define PFS_ST_FULL 1
`define PFS_ST_OVR 2
`define PFS_ST_LVL 3
`define PFS_ST_SENT 4
`define PFS_ST_MATCH 5

// pattern config fields
`define PFS_PC_EN 7
`define PFS_PC_LEN_HI 5
`define PFS_PC_LEN_LO 3
`define PFS_PC_TOL_HI 2
`define PFS_PC_TOL_LO 0
`define PFS_PCFG_RST 8'h98
`define PFS_PVAL_RST 64'h0101010101010101

// threshold and buffer
`define PFS_THR_RST 7'h0f
`define PFS_DEPTH 7'd66
`define PFS_LAST_IDX 7'd65

// bus answers
`define PFS_RESP_OK 2'b00
`define PFS_RESP_ERR 2'b10

`endif

// *** src/pfs_pkg.sv ***
package pfs_pkg;
    typedef enum logic [2:0] {
        PFS_SLEEP,
        PFS_STDBY,
        PFS_FS,
        PFS_RX,
        PFS_TX
    } pfs_mode_e;
    typedef logic [7:0] pfs_byte_t;
endpackage

// *** dv/pfs_packet_fifo_flags_checker.sv ***
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_packet_fifo_flags_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    // read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence stat_read;
        arvalid && arready && araddr == `PFS_OFF_STAT;
    endsequence
    wr_resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    rd_data_hold_a: assert property (rvalid && !rready
        |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped early");
    level_data_a: assert property (stat_read |=> !rdata[3] || rdata[0])
        else $error("level flag without data");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    wr_release_a: assert property ($rose(bvalid) |-> awready && wready)
        else $error("write beats not released with answer");
    aw_hold_a: assert property (awvalid && awready |=> !awready)
        else $error("second write address taken");
    bad_addr_a: assert property (arvalid && arready && araddr > 8'h20
        |=> rresp == `PFS_RESP_ERR && rdata == 32'h0) else $error("unmapped read answered");
    full_data_a: assert property (stat_read |=> !rdata[1] || rdata[0])
        else $error("full without data");
    full_level_a: assert property (stat_read |=> !(rdata[1] && rdata[3]))
        else $error("level flag while full");
    cover property (bvalid && bready);
    cover property (stat_read ##1 rdata[1]);
    cover property (arvalid && arready && araddr > 8'h20);
endmodule // pfs_packet_fifo_flags_checker

bind pfs_packet_fifo_flags pfs_packet_fifo_flags_checker chk_u (
    .mclk(mclk), .rstn(rstn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));

// *** dv/pfs_link_partner.sv ***
`timescale 1ns/1ps
module pfs_link_partner import pfs_pkg::*; (
    // link to the block
    output logic linkClk,
    output logic rxBit,
    input wire logic txBit
);
    initial begin
        linkClk = 1'b0;
        rxBit = 1'b1;
    end
    // clock stands still between frames; data changes while clock is low
    task automatic frame(input pfs_byte_t d, input int pulses, output pfs_byte_t got);
        got = 8'h00;
        #7;
        for (int i = 0; i < pulses; i++) begin
            rxBit = (i < 8) ? d[7 - i] : ~rxBit;
            #80;
            if (i > 0 && i < 9) got[8 - i] = txBit;
            linkClk = 1'b1;
            #80;
            linkClk = 1'b0;
        end
        rxBit = ~rxBit;
    endtask
endmodule // pfs_link_partner

// *** dv/pfs_packet_fifo_flags_tb_top.sv ***
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_packet_fifo_flags_tb_top;
    typedef struct {logic [31:0] val; logic [31:0] msk; logic [1:0] resp;} pfs_exp_s;
    logic mclk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, lowBattery = 1'b0, autoSequence = 1'b0;
    logic modeSwitchDone = 1'b0, dividedClock = 1'b0, synthLocked = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, got, b;
    logic [31:0] wdata = 32'h0, seen, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, linkClk, rxBit, txBit;
    logic [1:0] bresp, rresp;
    logic [5:0] generalPin, e6;
    logic [7:0] pcTab[5] = '{8'h80, 8'h80, 8'h81, 8'h00, 8'h80};
    logic [7:0] rxTab[5] = '{8'h01, 8'h03, 8'h03, 8'h01, 8'h80};
    logic [7:0] mapTab[3] = '{8'ha0, 8'h30, 8'h00};
    logic [4:0] hitMask = 5'b00101;
    pfs_exp_s rdQ[$], sideQ[$];
    logic [1:0] wrQ[$];
    logic [7:0] mdl[$];
    int num_errors = 0, comparisons = 0;
    event seenEv;

    pfs_packet_fifo_flags dut_u (.mclk(mclk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .linkClk(linkClk), .rxBit(rxBit), .txBit(txBit), .lowBattery(lowBattery),
        .autoSequence(autoSequence), .modeSwitchDone(modeSwitchDone),
        .dividedClock(dividedClock), .synthLocked(synthLocked), .generalPin(generalPin));
    pfs_link_partner link_u (.linkClk(linkClk), .rxBit(rxBit), .txBit(txBit));

    always #10 mclk = ~mclk;

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one bus access; the answer is compared by the monitor
    task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        if (w) begin
            wrQ.push_back(r);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            rdQ.push_back('{d, m, r});
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        do begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
        end while (!(w ? bvalid : rvalid) && n < 60);
        if (n >= 60) begin
            num_errors++;
            $display("mismatch at %0t: bus answer missing", $time);
        end
        bready <= 1'b0;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 32'h0, `PFS_RESP_OK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        acc(1'b0, a, v, m, `PFS_RESP_OK);
    endtask

    task automatic note(input logic [31:0] v, input logic [31:0] m, input logic [31:0] a);
        sideQ.push_back('{v, m, 2'b00});
        seen = a;
        -> seenEv;
        #1;
    endtask

    task automatic fill(input int n);
        repeat (n) begin
            b = 8'($urandom);
            mdl.push_back(b);
            wr(`PFS_OFF_FIFO, {24'h0, b});
        end
    endtask

    always @(posedge mclk) begin
        if (rvalid && rready) begin
            chk(((rdata ^ rdQ[0].val) & rdQ[0].msk) === 32'h0 && rresp === rdQ[0].resp, "read");
            void'(rdQ.pop_front());
        end
        if (bvalid && bready) begin
            chk(bresp === wrQ[0], "write response");
            void'(wrQ.pop_front());
        end
    end

    always @(seenEv) begin
        chk(((seen ^ sideQ[0].val) & sideQ[0].msk) === 32'h0, "observed value");
        void'(sideQ.pop_front());
    end

    initial begin
        #200us;
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        void'($urandom(32'h62de));
        rd(`PFS_OFF_MODE, 32'h01, 32'h1f);
        rd(`PFS_OFF_THR, 32'h0f, 32'h7f);
        rd(`PFS_OFF_PCFG, 32'h98, 32'hff);
        rd(`PFS_OFF_PHI, 32'h01010101, '1);
        rd(`PFS_OFF_STAT, 32'h0, 32'h3f);
        acc(1'b0, 8'h40, 32'h0, '1, `PFS_RESP_ERR);
        acc(1'b1, 8'h40, 32'hff, 32'h0, `PFS_RESP_ERR);
        wr(`PFS_OFF_PLO, 32'h5a3cc35a);
        rd(`PFS_OFF_PLO, 32'h5a3cc35a, '1);
        // level flag against threshold
        fill(15);
        rd(`PFS_OFF_STAT, 32'h01, 32'h0f);
        fill(1);
        rd(`PFS_OFF_STAT, 32'h09, 32'h0f);
        wr(`PFS_OFF_THR, 32'h20);
        rd(`PFS_OFF_STAT, 32'h09, 32'h0f);
        rd(`PFS_OFF_FIFO, {24'h0, mdl.pop_front()}, 32'hff);
        rd(`PFS_OFF_STAT, 32'h01, 32'h0f);
        wr(`PFS_OFF_STAT, 32'h04);
        mdl.delete();
        rd(`PFS_OFF_STAT, 32'h0, 32'h0f);
        // full, overrun, drain
        fill(66);
        rd(`PFS_OFF_STAT, 32'h03, 32'h0f);
        wr(`PFS_OFF_FIFO, 32'h77);
        rd(`PFS_OFF_STAT, 32'h07, 32'h0f);
        do begin
            rd(`PFS_OFF_FIFO, {24'h0, mdl.pop_front()}, 32'hff);
            rd(`PFS_OFF_STAT, {31'h0, mdl.size() != 0}, 32'h01);
        end while (rdata[0] === 1'b1);
        rd(`PFS_OFF_STAT, 32'h04, 32'h0f);
        rd(`PFS_OFF_FIFO, 32'h0, 32'hff);
        fill(3);
        wr(`PFS_OFF_STAT, 32'h04);
        mdl.delete();
        rd(`PFS_OFF_STAT, 32'h0, 32'h0f);
        // mode transitions and transmit
        fill(1);
        wr(`PFS_OFF_MODE, 32'h0);
        rd(`PFS_OFF_STAT, 32'h01, 32'h01);
        wr(`PFS_OFF_MODE, 32'h4);
        rd(`PFS_OFF_STAT, 32'h01, 32'h01);
        link_u.frame(8'h00, 9, got);
        repeat (4) @(posedge mclk);
        note({24'h0, mdl[0]}, 32'hff, {24'h0, got});
        rd(`PFS_OFF_STAT, 32'h10, 32'h11);
        fill(1);
        wr(`PFS_OFF_MODE, 32'h1);
        rd(`PFS_OFF_STAT, 32'h0, 32'h01);
        fill(1);
        wr(`PFS_OFF_MODE, 32'h3);
        rd(`PFS_OFF_STAT, 32'h0, 32'h01);
        wr(`PFS_OFF_MODE, 32'h1);
        // pattern detection
        for (int k = 0; k < 5; k++) begin
            wr(`PFS_OFF_PCFG, {24'h0, pcTab[k]});
            wr(`PFS_OFF_MODE, 32'h3);
            link_u.frame(rxTab[k], 8, got);
            repeat (4) @(posedge mclk);
            rd(`PFS_OFF_STAT, {26'h0, hitMask[k], 5'h0}, 32'h20);
            wr(`PFS_OFF_MODE, 32'h1);
            rd(`PFS_OFF_STAT, 32'h01, 32'h21);
        end
        // two-byte pattern, flag clears when the buffer drains
        wr(`PFS_OFF_PCFG, 32'h88);
        wr(`PFS_OFF_MODE, 32'h3);
        repeat (2) link_u.frame(8'h01, 8, got);
        repeat (4) @(posedge mclk);
        rd(`PFS_OFF_STAT, 32'h21, 32'h21);
        repeat (2) rd(`PFS_OFF_FIFO, 32'h01, 32'hff);
        rd(`PFS_OFF_STAT, 32'h0, 32'h21);
        wr(`PFS_OFF_MODE, 32'h1);
        // pin routing in continuous standby
        wr(`PFS_OFF_MODE, 32'h19);
        wr(`PFS_OFF_MAP1, 32'ha2);
        for (int k = 0; k < 6; k++) begin
            lowBattery <= 1'($urandom);
            autoSequence <= 1'($urandom);
            modeSwitchDone <= 1'($urandom);
            dividedClock <= 1'($urandom);
            synthLocked <= 1'($urandom);
            wr(`PFS_OFF_MAP2, {24'h0, mapTab[k % 3]});
            repeat (3) @(posedge mclk);
            e6 = (k % 3 == 0)
                ? {lowBattery, lowBattery, autoSequence, 1'b0, lowBattery, lowBattery}
                : {(k % 3 == 1) ? modeSwitchDone : dividedClock, 5'h0};
            note({26'h0, e6}, (k % 3 == 0) ? 32'h3b : 32'h20, {26'h0, generalPin});
        end
        final_report();
    end
endmodule // pfs_packet_fifo_flags_tb_top
